// ===== core/tmic_consts.svh
`ifndef TMIC_CONSTS_SVH
`define TMIC_CONSTS_SVH
`define TMIC_OFF_STAT1 16'hA800
`define TMIC_OFF_STAT2 16'hA804
`define TMIC_OFF_MISS1 16'hA818
`define TMIC_OFF_MISS2 16'hA81C
`define TMIC_OFF_IEN1 16'hA840
`define TMIC_OFF_IEN2 16'hA844
`define TMIC_OFF_CTL1 16'hE000
`define TMIC_OFF_CTL2 16'hF000
`define TMIC_STAT_MASK 32'h0000005F
`define TMIC_MISS_LSB 9
`define TMIC_CTL_MASK 32'h000000FF
`define TMIC_RESET_VAL 32'h00000000
`define TMIC_BIT_CEN 0
`define TMIC_BIT_UPDATE_INHIBIT 1
`define TMIC_BIT_URS 2
`define TMIC_BIT_OPM 3
`define TMIC_BIT_DIR 4
`define TMIC_BIT_PERIOD_PRELOAD_ENABLE 7
`define TMIC_SLAVE_TRIGGER 3'h6
`define TMIC_SLAVE_GATED 3'h5
`endif

// ===== core/tmic_pkg.sv
package tmic_pkg;
    typedef struct packed {
        logic period_preload_enable;
        logic [1:0] alignment_select;
        logic dir_down;
        logic single_shot_select;
        logic update_source_select;
        logic update_inhibit;
        logic counter_enable_bit;
    } tmic_ctl_s;
    // Per-timer event inputs from the counter core, all pclk-synchronous
    typedef struct packed {
        logic trig_level;
        logic [2:0] slave_mode;
        logic [3:0] chan_capture;
        logic [3:0] chan_compare;
        logic [3:0] chan_is_capture;
        logic [3:0] ccr_read;
        logic count_down;
        logic overflow;
        logic software_update_request;
        logic slave_update;
    } tmic_evt_s;
endpackage : tmic_pkg

// ===== core/tmic_top.sv
`timescale 1ns/10ps
`include "tmic_consts.svh"
module tmic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tmic_pkg::tmic_evt_s evt [2],
    output tmic_pkg::tmic_ctl_s ctl [2],
    output logic [1:0] irq,
    output logic [1:0] update_event,
    output logic [1:0] shadow_load
);

////////////////////////////////////////////////////////////////////////////////
// APB decode: zero wait states, unmapped addresses answer with pslverr
logic acc;
logic wr;
logic rd;
assign acc = psel & penable;
assign wr = acc & pwrite;
assign rd = acc & ~pwrite;

logic [1:0] sel_stat;
logic [1:0] sel_miss;
logic [1:0] sel_ien;
logic [1:0] sel_ctl;
assign sel_stat = {paddr == `TMIC_OFF_STAT2, paddr == `TMIC_OFF_STAT1};
assign sel_miss = {paddr == `TMIC_OFF_MISS2, paddr == `TMIC_OFF_MISS1};
assign sel_ien = {paddr == `TMIC_OFF_IEN2, paddr == `TMIC_OFF_IEN1};
assign sel_ctl = {paddr == `TMIC_OFF_CTL2, paddr == `TMIC_OFF_CTL1};
logic mapped;
assign mapped = |{sel_stat, sel_miss, sel_ien, sel_ctl};

logic [6:0] stat_q [2];
logic [3:0] miss_q [2];
logic [6:0] ien_q [2];
tmic_pkg::tmic_ctl_s ctl_q [2];
logic [1:0] irq_q;
logic [1:0] upd_q;
logic [1:0] shl_q;
logic [1:0] trig_prev_q;
logic [31:0] prdata_q;
logic pslverr_q;
logic pready_q;

////////////////////////////////////////////////////////////////////////////////
// Per-timer event and flag logic
genvar t;
generate
    for (t = 0; t < 2; t++) begin : g_tim
        logic trig_rise;
        logic trig_fall;
        logic trig_evt;
        logic [3:0] cmp_ok;
        logic [3:0] ch_evt;
        logic upd_src;
        logic upd_evt;
        logic upd_flag;
        logic [6:0] set_stat;
        logic [6:0] clr_stat;
        logic [3:0] clr_miss;
        logic gated;
        logic trig_mode;

        assign gated = evt[t].slave_mode == `TMIC_SLAVE_GATED;
        assign trig_mode = evt[t].slave_mode == `TMIC_SLAVE_TRIGGER;
        assign trig_rise = evt[t].trig_level & ~trig_prev_q[t];
        assign trig_fall = ~evt[t].trig_level & trig_prev_q[t];
        assign trig_evt = trig_rise | (gated & trig_fall);

        // Compare flags in alignment codes 1 and 2 only on the selected counting direction; codes 0 and 3 flag both
        always_comb begin
            unique case (ctl_q[t].alignment_select)
                2'h0: cmp_ok = 4'hF;
                2'h1: cmp_ok = {4{evt[t].count_down}};
                2'h2: cmp_ok = {4{~evt[t].count_down}};
                2'h3: cmp_ok = 4'hF;
            endcase
        end
        assign ch_evt = evt[t].chan_capture | (evt[t].chan_compare & cmp_ok);

        // Update events from overflow, software request or slave reset
        assign upd_src = evt[t].overflow | evt[t].software_update_request | evt[t].slave_update;
        assign upd_evt = upd_src & ~ctl_q[t].update_inhibit;
        // Software and slave updates may be kept out of the flag
        assign upd_flag = upd_evt & (evt[t].overflow | ~ctl_q[t].update_source_select);

        assign set_stat = {trig_evt, 1'b0, ch_evt, upd_flag};
        // Only ones clear; zeros leave the flag alone
        assign clr_stat = (wr & sel_stat[t]) ? pwdata[6:0] : 7'h00;
        assign clr_miss = (wr & sel_miss[t]) ? pwdata[12:9] : 4'h0;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                trig_prev_q[t] <= 1'b0;
            end else begin
                trig_prev_q[t] <= evt[t].trig_level;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat_q[t] <= 7'h00;
            end else begin
                // Set term is ORed last so it beats a same-cycle clear
                stat_q[t] <= ((stat_q[t] & ~clr_stat
                    & ~{2'h0, evt[t].ccr_read & evt[t].chan_is_capture, 1'b0})
                    | set_stat) & 7'h5F;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                miss_q[t] <= 4'h0;
            end else begin
                miss_q[t] <= (miss_q[t] & ~clr_miss) | (ch_evt & stat_q[t][4:1]);
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ien_q[t] <= 7'h00;
            end else if (wr & sel_ien[t]) begin
                ien_q[t] <= pwdata[6:0] & 7'h5F;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl_q[t] <= '0;
            end else if (wr & sel_ctl[t]) begin
                ctl_q[t] <= tmic_pkg::tmic_ctl_s'(pwdata[7:0]);
            end else if (trig_mode & trig_rise) begin
                ctl_q[t].counter_enable_bit <= 1'b1;
            end else if (upd_evt & ctl_q[t].single_shot_select) begin
                ctl_q[t].counter_enable_bit <= 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_q[t] <= 1'b0;
                upd_q[t] <= 1'b0;
                shl_q[t] <= 1'b0;
            end else begin
                irq_q[t] <= |(stat_q[t] & ien_q[t]);
                upd_q[t] <= upd_evt;
                shl_q[t] <= upd_evt;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read data; reserved bits read as zero
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_q <= `TMIC_RESET_VAL;
        pslverr_q <= 1'b0;
        pready_q <= 1'b0;
    end else begin
        pready_q <= 1'b1;
        // Raised by the setup cycle, so it stands exactly in the access phase
        pslverr_q <= psel & ~penable & ~mapped;
        prdata_q <= 32'h00000000;
        if (psel & ~penable & ~pwrite) begin
            if (paddr == `TMIC_OFF_STAT1) prdata_q <= {25'h0, stat_q[0]};
            if (paddr == `TMIC_OFF_STAT2) prdata_q <= {25'h0, stat_q[1]};
            if (paddr == `TMIC_OFF_MISS1) prdata_q <= {19'h0, miss_q[0], 9'h000};
            if (paddr == `TMIC_OFF_MISS2) prdata_q <= {19'h0, miss_q[1], 9'h000};
            if (paddr == `TMIC_OFF_IEN1) prdata_q <= {25'h0, ien_q[0]};
            if (paddr == `TMIC_OFF_IEN2) prdata_q <= {25'h0, ien_q[1]};
            if (paddr == `TMIC_OFF_CTL1) prdata_q <= {24'h0, ctl_q[0]};
            if (paddr == `TMIC_OFF_CTL2) prdata_q <= {24'h0, ctl_q[1]};
        end
    end
end

assign prdata = prdata_q;
assign pslverr = pslverr_q;
assign pready = pready_q;
assign irq = irq_q;
assign update_event = upd_q;
assign shadow_load = shl_q;
assign ctl = ctl_q;

////////////////////////////////////////////////////////////////////////////////
// Checks

status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g_tim[0].set_stat[0]) |=> stat_q[0][0])
    else $error("update flag lost");
irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat_q[0] & ien_q[0]) == 7'h00) |=> !irq_q[0])
    else $error("irq without enabled flag");
clear_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `TMIC_OFF_STAT1 && pwdata[6] && !g_tim[0].trig_evt) |=> !stat_q[0][6])
    else $error("trigger flag not cleared");
clear_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `TMIC_OFF_STAT1 && !pwdata[0] && stat_q[0][0]) |=> stat_q[0][0])
    else $error("flag cleared by zero");
missed_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g_tim[0].ch_evt[0] && stat_q[0][1]) |=> miss_q[0][0])
    else $error("missed flag not set");
inhibit_upd_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[0].update_inhibit |=> !update_event[0])
    else $error("update under inhibit");
oneshot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g_tim[0].upd_evt && ctl_q[0].single_shot_select && !(wr && sel_ctl[0])
    && !(g_tim[0].trig_mode && g_tim[0].trig_rise)) |=> !ctl_q[0].counter_enable_bit)
    else $error("single shot did not stop");
trig_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (g_tim[0].trig_mode && g_tim[0].trig_rise && !(wr && sel_ctl[0])) |=> ctl_q[0].counter_enable_bit)
    else $error("trigger did not start counter");
bit5_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !stat_q[0][5] && !stat_q[1][5])
    else $error("reserved status bit set");

////////////////////////////////////////////////////////////////////////////////
// Per-timer checks, written from the register map rather than from the flag logic.
// The trigger checks skip the first edge after reset, where the edge detector
// still holds its reset value instead of the level seen one cycle earlier.
// Clear checks leave out cycles with an event on the same flag, since set wins.
generate
    for (t = 0; t < 2; t++) begin : g_chk
        trig_rise_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            $past(presetn) && evt[t].trig_level && !$past(evt[t].trig_level) |=> stat_q[t][6])
            else $error("trigger rise not flagged");

        trig_gated_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            $past(presetn) && evt[t].slave_mode == `TMIC_SLAVE_GATED && !evt[t].trig_level
            && $past(evt[t].trig_level) |=> stat_q[t][6])
            else $error("gated trigger fall not flagged");

        chan_flag_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            evt[t].chan_capture != 4'h0
            |=> (stat_q[t][4:1] & $past(evt[t].chan_capture)) == $past(evt[t].chan_capture))
            else $error("capture event not flagged");

        upd_flag_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            evt[t].overflow && !ctl_q[t].update_inhibit |=> stat_q[t][0])
            else $error("overflow not flagged");

        stat_clear_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr && sel_stat[t] && pwdata[1] && !evt[t].chan_capture[0] && !evt[t].chan_compare[0]
            |=> !stat_q[t][1])
            else $error("channel flag not cleared");

        ccr_clear_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            evt[t].ccr_read[0] && evt[t].chan_is_capture[0] && !evt[t].chan_capture[0]
            && !evt[t].chan_compare[0] |=> !stat_q[t][1])
            else $error("value read did not clear flag");

        irq_raise_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            (stat_q[t] & ien_q[t]) != 7'h00 |=> irq[t])
            else $error("enabled flag without irq");

        miss_flag_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            evt[t].chan_capture[3] && stat_q[t][4] |=> miss_q[t][3])
            else $error("missed event not recorded");

        miss_clear_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr && sel_miss[t] && pwdata[9] && !evt[t].chan_capture[0] && !evt[t].chan_compare[0]
            |=> !miss_q[t][0])
            else $error("missed flag not cleared");

        miss_keep_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr && sel_miss[t] && !pwdata[9] && miss_q[t][0] |=> miss_q[t][0])
            else $error("missed flag cleared by zero");

        // Read data was captured in the setup cycle, so it is held against last cycle's flags
        stat_read_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            rd && sel_stat[t] |-> prdata == {25'h0, $past(stat_q[t])})
            else $error("status read layout wrong");

        miss_read_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            rd && sel_miss[t] |-> prdata == {19'h0, $past(miss_q[t]), 9'h000})
            else $error("missed read layout wrong");

        ien_write_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr && sel_ien[t] |=> ien_q[t] == ($past(pwdata[6:0]) & 7'h5F))
            else $error("enable write wrong");

        ctl_write_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr && sel_ctl[t] |=> 8'(ctl[t]) == $past(pwdata[7:0]))
            else $error("control write wrong");

        // Compare flags follow the counting direction in alignment codes 1 and 2; code 3 flags both directions
        edge_cmp_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            ctl_q[t].alignment_select == 2'h0 && evt[t].chan_compare[0] |=> stat_q[t][1])
            else $error("edge mode compare not flagged");

        cmp_down_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            ctl_q[t].alignment_select == 2'h1 && !evt[t].count_down && !stat_q[t][1]
            && evt[t].chan_compare[0] && !evt[t].chan_capture[0] |=> !stat_q[t][1])
            else $error("compare flagged while counting up");

        cmp_up_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            ctl_q[t].alignment_select == 2'h2 && evt[t].count_down && !stat_q[t][1]
            && evt[t].chan_compare[0] && !evt[t].chan_capture[0] |=> !stat_q[t][1])
            else $error("compare flagged while counting down");

        cmp_both_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            ctl_q[t].alignment_select == 2'h3 && evt[t].chan_compare[0] |=> stat_q[t][1])
            else $error("compare not flagged in both directions");

        upd_src_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            ctl_q[t].update_source_select && !evt[t].overflow && !stat_q[t][0] |=> !stat_q[t][0])
            else $error("update flag from filtered source");

        upd_out_a: assert property (
            @(posedge pclk) disable iff (!presetn)
            evt[t].overflow && !ctl_q[t].update_inhibit |=> update_event[t] && shadow_load[t])
            else $error("overflow gave no update");
    end
endgenerate

irq_seen_c: cover property (@(posedge pclk) disable iff (!presetn) irq_q[0]);
missed_seen_c: cover property (@(posedge pclk) disable iff (!presetn) miss_q[1] != 4'h0);
oneshot_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(ctl_q[0].counter_enable_bit));
setclr_c: cover property (@(posedge pclk) disable iff (!presetn) g_tim[0].set_stat[0] && g_tim[0].clr_stat[0]);
inhibit_c: cover property (@(posedge pclk) disable iff (!presetn) ctl_q[0].update_inhibit && g_tim[0].upd_src);

endmodule : tmic_top

// ===== verif/tmic_top_bench.sv
`timescale 1ns/10ps
`include "tmic_consts.svh"
module tmic_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [1:0] irq, update_event, shadow_load;
    tmic_pkg::tmic_evt_s evt [2];
    tmic_pkg::tmic_evt_s lvl [2];
    tmic_pkg::tmic_evt_s p;
    tmic_pkg::tmic_ctl_s ctl [2];
    logic [15:0] ra [8] = '{`TMIC_OFF_STAT1, `TMIC_OFF_STAT2, `TMIC_OFF_MISS1, `TMIC_OFF_MISS2,
                            `TMIC_OFF_IEN1, `TMIC_OFF_IEN2, `TMIC_OFF_CTL1, `TMIC_OFF_CTL2};
    int ue_cnt [2] = '{0, 0};
    int sl_cnt [2] = '{0, 0};
    int failures = 0;
    int n_tests = 0;
    int tm, c, n0, n1;

    tmic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt(evt), .ctl(ctl), .irq(irq), .update_event(update_event), .shadow_load(shadow_load));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // Update pulses last one cycle, so they are counted rather than sampled
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            if (update_event[i] === 1'h1) ue_cnt[i]++;
            if (shadow_load[i] === 1'h1) sl_cnt[i]++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until the edge that sees pready high; read data and error are taken there
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic fire(input int t, input tmic_pkg::tmic_evt_s pl);
        evt[t] <= lvl[t] | pl;
        @(posedge pclk);
        evt[t] <= lvl[t];
        repeat (2) @(posedge pclk);
    endtask : fire

    task automatic chk_irq(input int t, input logic [31:0] exp);
        @(negedge pclk);
        chk(32'(irq[t]), exp);
        @(posedge pclk);
    endtask : chk_irq

    function automatic logic cmp_exp(input int al, input logic dn);
        return (al == 1) ? dn : (al == 2) ? ~dn : 1'h1;
    endfunction : cmp_exp

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        lvl = '{'0, '0};
        evt = '{'0, '0};
        void'($urandom(26316));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            apb(1'h0, ra[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'h0, 16'hA808, 32'h0);
        chk(32'(err), 32'h1);
        $display("test reset_values done");
        tm = int'($urandom % 2);
        c = int'($urandom % 4);
        p = '0;
        p.overflow = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h1);
        chk_irq(tm, 32'h0);
        apb(1'h1, ra[4 + tm], 32'h1);
        chk_irq(tm, 32'h1);
        apb(1'h1, ra[tm], 32'h0);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h1);
        apb(1'h1, ra[tm], 32'h1);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h0);
        chk_irq(tm, 32'h0);
        $display("test update_flag done");
        p = '0;
        p.chan_capture[c] = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h1 << (c + 1));
        fire(tm, p);
        apb(1'h0, ra[2 + tm], 32'h0);
        chk(rd, 32'h1 << (c + 9));
        apb(1'h1, ra[2 + tm], 32'h1 << (c + 9));
        apb(1'h0, ra[2 + tm], 32'h0);
        chk(rd, 32'h0);
        p = '0;
        p.ccr_read[c] = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h1 << (c + 1));
        lvl[tm].chan_is_capture[c] = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h0);
        $display("test channel_missed done");
        for (int i = 0; i < 4; i++) begin
            lvl[tm].slave_mode = (i > 1) ? `TMIC_SLAVE_GATED : 3'h0;
            lvl[tm].trig_level = (i % 2 == 0);
            fire(tm, '0);
            apb(1'h0, ra[tm], 32'h0);
            chk(rd, (i == 1) ? 32'h0 : 32'h40);
            apb(1'h1, ra[tm], 32'h40);
        end
        lvl[tm].slave_mode = `TMIC_SLAVE_TRIGGER;
        lvl[tm].trig_level = 1'h1;
        fire(tm, '0);
        apb(1'h0, ra[6 + tm], 32'h0);
        chk(rd, 32'h1);
        lvl[tm] = '0;
        fire(tm, '0);
        $display("test trigger done");
        p = '0;
        p.overflow = 1'h1;
        apb(1'h1, ra[6 + tm], 32'h9);
        fire(tm, p);
        apb(1'h0, ra[6 + tm], 32'h0);
        chk(rd, 32'h8);
        apb(1'h1, ra[tm], 32'h7F);
        apb(1'h1, ra[6 + tm], 32'h3);
        n0 = ue_cnt[tm];
        n1 = sl_cnt[tm];
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h0);
        chk(32'(ue_cnt[tm] - n0), 32'h0);
        chk(32'(sl_cnt[tm] - n1), 32'h0);
        apb(1'h1, ra[6 + tm], 32'h5);
        p = '0;
        p.software_update_request = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h0);
        chk(32'(ue_cnt[tm] - n0), 32'h1);
        chk(32'(sl_cnt[tm] - n1), 32'h1);
        p = '0;
        p.slave_update = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h0);
        chk(32'(ue_cnt[tm] - n0), 32'h2);
        p = '0;
        p.overflow = 1'h1;
        fire(tm, p);
        apb(1'h0, ra[tm], 32'h0);
        chk(rd, 32'h1);
        apb(1'h1, ra[tm], 32'h1);
        $display("test update_control done");
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, ra[6 + tm], 32'(i / 2) << 5);
            lvl[tm].count_down = i[0];
            p = '0;
            p.chan_compare[c] = 1'h1;
            fire(tm, p);
            apb(1'h0, ra[tm], 32'h0);
            chk(rd, cmp_exp(i / 2, i[0]) ? (32'h1 << (c + 1)) : 32'h0);
            apb(1'h1, ra[tm], 32'h1E);
        end
        $display("test alignment done");
        apb(1'h1, ra[6 + tm], 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'hFFFFFFFE;
            apb(1'h1, ra[6 + tm], v);
            apb(1'h0, ra[6 + tm], 32'h0);
            chk(rd, v & 32'hFF);
            chk(32'(ctl[tm]), v & 32'hFF);
        end
        $display("test control_readback done");
        final_report;
    end

    // Whole sequence needs well under two thousand cycles
    initial begin
        #100000;
        failures++;
        final_report;
    end
endmodule : tmic_top_bench
